//--- acs_map.svh
// offsets, field positions, reset values and timing counts of the converter controller
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

// clock period and timing figures
`define ACS_MCLK_PS 4000
`define ACS_TD_RST_NS 1000
`define ACS_TCONV_NS 300
`define ACS_TD_CSRDY_NS 20
`define ACS_TD_RST_CYC ((`ACS_TD_RST_NS * 1000 + `ACS_MCLK_PS - 1) / `ACS_MCLK_PS)
`define ACS_TCONV_CYC ((`ACS_TCONV_NS * 1000 + `ACS_MCLK_PS - 1) / `ACS_MCLK_PS)
`define ACS_TD_CSRDY_CYC ((`ACS_TD_CSRDY_NS * 1000 + `ACS_MCLK_PS - 1) / `ACS_MCLK_PS)

// command word fields
`define ACS_WORD_W 22
`define ACS_OPC_HI 21
`define ACS_OPC_LO 17
`define ACS_ADR_HI 16
`define ACS_ADR_LO 8
`define ACS_DAT_HI 7
`define ACS_DAT_LO 0
`define ACS_OPC_CLR 5'h10
`define ACS_OPC_RD 5'h11
`define ACS_OPC_WR 5'h12
`define ACS_OPC_SET 5'h13

// configuration registers
`define ACS_NREG 4
`define ACS_ADR_CTRL 9'h000
`define ACS_ADR_PAT0 9'h001
`define ACS_ADR_PAT1 9'h002
`define ACS_ADR_PAT2 9'h003
`define ACS_CTRL_PARITY_ENABLE 0
`define ACS_CTRL_SPAN_LO 1
`define ACS_CTRL_SPAN_HI 2
`define ACS_CTRL_PAT_EN 3
`define ACS_REG_RST 8'h00

// output word layout
`define ACS_RES_W 20
`define ACS_RD_LSB 14
`define ACS_SAT_POS 20'h7FFFF
`define ACS_SAT_NEG 20'h80000

`endif

//--- acs_pkg.sv
// types of the converter state and serial frame controller
package acs_pkg;

  typedef enum logic [1:0] {
    ACS_RST = 2'b00,
    ACS_EXIT = 2'b01,
    ACS_ACQ = 2'b11,
    ACS_CNV = 2'b10
  } acs_state_t;

  typedef struct packed {
    logic [2:0] conv_sync;
    logic [2:0] cs_sync;
    logic [2:0] sclk_sync;
    logic [1:0] sdi_sync;
    acs_state_t st;
    logic [15:0] tmr;
    logic [19:0] result;
    logic frame;
    logic [4:0] cnt;
    logic [21:0] output_shift_register;
    logic [21:0] input_shift_register;
    logic [7:0] rd_byte;
    logic rd_pend;
    logic [3:0][7:0] regs;
    logic [7:0] rdy_tmr;
    logic rdy_ok;
  } acs_regs_t;

endpackage

//--- acs_ctrl.sv
// converter state machine and 22-bit serial command/response frame
//
// Behaviour
// - reset pin is asynchronous, held low minimum time
// - reset: defaults, ready low, data output floating
// - after exit delay: acquire, ready goes high
// - status low converting; ready mirrors it outside frames and their ready delay
// - acquire after reset and after each conversion
// - reset falls to reset; start rises to convert
// - start edges ignored while converting
// - opcode 21:17, address 16:8, data 7:0
// - clear, set masked bits; write byte; read
// - all-zero, all-one and reserved opcodes do nothing
// - readback byte in bits 21:14, rest zero
// - pattern enable puts the PAT2..PAT0 register pattern in 21:2
// - otherwise bits 21:2 hold latest result
// - parity bits zero, or word and span parity
// - select fall: ready low, load, clear counters
// - capture edge shifts in; launch edge shifts out
// - select rise: float, delayed ready, decode command
// - fewer than 22 clocks: command is ignored
// - 22 or more clocks: last 22 bits decode
// - short frames still deliver valid output bits
// - result saturates at 80000 and 7FFFF
`timescale 1ns/1ps
`include "acs_map.svh"

module acs_ctrl
  import acs_pkg::*;
#(
  parameter int RAW_W = 24
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // conversion start pin
  input wire logic CONVERSION_START_IN,
  // serial frame pins
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic SDI,
  output logic SDO,
  output logic SDO_OE,
  output logic READY_STATUS_OUT,
  // converter core
  input wire logic signed [RAW_W-1:0] CONV_RAW,
  output logic CONVERT_STATE,
  output logic CONVERSION_ACTIVE_FLAG,
  // configuration view
  output logic PARITY_ENABLE,
  output logic PATTERN_OVERRIDE_ENABLE
);

  localparam int TD_RST_CYC = `ACS_TD_RST_CYC;
  localparam int TCONV_CYC = `ACS_TCONV_CYC;
  localparam int TD_CSRDY_CYC = `ACS_TD_CSRDY_CYC;
  localparam logic [15:0] EXIT_LAST = 16'(TD_RST_CYC - 1);
  localparam logic [15:0] CONV_LAST = 16'(TCONV_CYC - 1);
  localparam logic [7:0] RDY_LAST = 8'(TD_CSRDY_CYC - 1);
  localparam logic [4:0] FULL_CNT = 5'(`ACS_WORD_W);

  acs_regs_t q;
  acs_regs_t d;

  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic conv_rise;
  logic sdi_s;
  logic [4:0] cmd_opc;
  logic [8:0] cmd_adr;
  logic [7:0] cmd_dat;
  logic adr_ok;
  logic [1:0] adr_idx;
  logic [7:0] ctrl;
  logic [19:0] pattern;
  logic [19:0] payload;
  logic [21:0] word;
  logic full_par;
  logic span_par;

  // saturate the core's wide two's complement value to 20 bits
  function automatic logic [19:0] acs_sat(input logic signed [RAW_W-1:0] v);
    logic in_range;
    in_range = (v[RAW_W-1:`ACS_RES_W-1] == {(RAW_W-`ACS_RES_W+1){v[RAW_W-1]}});
    if (in_range) begin
      acs_sat = v[`ACS_RES_W-1:0];
    end else if (v[RAW_W-1]) begin
      acs_sat = `ACS_SAT_NEG;
    end else begin
      acs_sat = `ACS_SAT_POS;
    end
  endfunction

  // edges come from the second and third sync stages only
  assign cs_fall = q.cs_sync[2] & ~q.cs_sync[1];
  assign cs_rise = ~q.cs_sync[2] & q.cs_sync[1];
  assign sclk_rise = ~q.sclk_sync[2] & q.sclk_sync[1];
  assign sclk_fall = q.sclk_sync[2] & ~q.sclk_sync[1];
  assign conv_rise = ~q.conv_sync[2] & q.conv_sync[1];
  assign sdi_s = q.sdi_sync[1];

  assign cmd_opc = q.input_shift_register[`ACS_OPC_HI:`ACS_OPC_LO];
  assign cmd_adr = q.input_shift_register[`ACS_ADR_HI:`ACS_ADR_LO];
  assign cmd_dat = q.input_shift_register[`ACS_DAT_HI:`ACS_DAT_LO];
  assign adr_ok = (cmd_adr < 9'(`ACS_NREG));
  assign adr_idx = cmd_adr[1:0];

  assign ctrl = q.regs[`ACS_ADR_CTRL];
  assign pattern = {q.regs[`ACS_ADR_PAT2][3:0], q.regs[`ACS_ADR_PAT1], q.regs[`ACS_ADR_PAT0]};

  // output word: readback first, then pattern, then result
  always_comb begin
    payload = ctrl[`ACS_CTRL_PAT_EN] ? pattern : q.result;
    full_par = ^payload;
    unique case (ctrl[`ACS_CTRL_SPAN_HI:`ACS_CTRL_SPAN_LO])
      2'h0: span_par = ^payload[19:16];
      2'h1: span_par = ^payload[19:12];
      2'h2: span_par = ^payload[19:8];
      2'h3: span_par = ^payload[19:0];
    endcase
    if (q.rd_pend) begin
      word = {q.rd_byte, {`ACS_RD_LSB{1'b0}}};
    end else if (ctrl[`ACS_CTRL_PARITY_ENABLE]) begin
      word = {payload, full_par, span_par};
    end else begin
      word = {payload, 2'b00};
    end
  end

  always_comb begin
    d = q;
    d.conv_sync = {q.conv_sync[1:0], CONVERSION_START_IN};
    d.cs_sync = {q.cs_sync[1:0], CS_N};
    d.sclk_sync = {q.sclk_sync[1:0], SCLK};
    d.sdi_sync = {q.sdi_sync[0], SDI};

    // conversion state machine; the reset state is only left after release
    unique case (q.st)
      ACS_RST: begin
        d.st = ACS_EXIT;
        d.tmr = 16'h0000;
      end
      ACS_EXIT: begin
        d.tmr = q.tmr + 16'h0001;
        if (q.tmr == EXIT_LAST) begin
          d.st = ACS_ACQ;
        end
      end
      ACS_ACQ: begin
        if (conv_rise) begin
          d.st = ACS_CNV;
          d.tmr = 16'h0000;
        end
      end
      ACS_CNV: begin
        // start edges are simply not looked at here
        d.tmr = q.tmr + 16'h0001;
        if (q.tmr == CONV_LAST) begin
          d.st = ACS_ACQ;
          d.result = acs_sat(CONV_RAW);
        end
      end
    endcase

    // delayed ready after a frame ends
    if (!q.rdy_ok) begin
      d.rdy_tmr = q.rdy_tmr + 8'h01;
      if (q.rdy_tmr == RDY_LAST) begin
        d.rdy_ok = 1'b1;
      end
    end

    if (cs_fall) begin
      d.frame = 1'b1;
      d.cnt = 5'h00;
      d.input_shift_register = 22'h000000;
      d.output_shift_register = word;
      d.rd_pend = 1'b0;
    end else if (cs_rise) begin
      d.frame = 1'b0;
      d.rdy_ok = 1'b0;
      d.rdy_tmr = 8'h00;
      // short frames leave the registers and readback untouched
      if (q.frame && q.cnt >= FULL_CNT) begin
        unique case (cmd_opc)
          `ACS_OPC_CLR: begin
            if (adr_ok) begin
              d.regs[adr_idx] = q.regs[adr_idx] & ~cmd_dat;
            end
          end
          `ACS_OPC_SET: begin
            if (adr_ok) begin
              d.regs[adr_idx] = q.regs[adr_idx] | cmd_dat;
            end
          end
          `ACS_OPC_WR: begin
            if (adr_ok) begin
              d.regs[adr_idx] = cmd_dat;
            end
          end
          `ACS_OPC_RD: begin
            if (adr_ok) begin
              d.rd_byte = q.regs[adr_idx];
              d.rd_pend = 1'b1;
            end
          end
          default: begin
            // nop words and reserved opcodes
            d.rd_pend = q.rd_pend;
          end
        endcase
      end
    end else if (q.frame) begin
      if (sclk_rise) begin
        // counter saturates at 22 so that any longer frame stays long
        if (q.cnt < FULL_CNT) begin
          d.cnt = q.cnt + 5'h01;
        end
        d.input_shift_register = {q.input_shift_register[20:0], sdi_s};
      end
      if (sclk_fall) begin
        d.output_shift_register = {q.output_shift_register[20:0], 1'b0};
      end
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      q.conv_sync <= 3'h0;
      q.cs_sync <= 3'h7;
      q.sclk_sync <= 3'h0;
      q.sdi_sync <= 2'h0;
      q.st <= ACS_RST;
      q.tmr <= 16'h0000;
      q.result <= 20'h00000;
      q.frame <= 1'b0;
      q.cnt <= 5'h00;
      q.output_shift_register <= 22'h000000;
      q.input_shift_register <= 22'h000000;
      q.rd_byte <= 8'h00;
      q.rd_pend <= 1'b0;
      q.regs <= {`ACS_NREG{`ACS_REG_RST}};
      q.rdy_tmr <= 8'h00;
      q.rdy_ok <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // the status line is low while converting and during reset exit
  assign CONVERSION_ACTIVE_FLAG = (q.st == ACS_ACQ);
  assign CONVERT_STATE = (q.st == ACS_CNV);
  assign READY_STATUS_OUT = CONVERSION_ACTIVE_FLAG & ~q.frame & q.rdy_ok;
  assign SDO = q.output_shift_register[21];
  assign SDO_OE = q.frame;
  assign PARITY_ENABLE = ctrl[`ACS_CTRL_PARITY_ENABLE];
  assign PATTERN_OVERRIDE_ENABLE = ctrl[`ACS_CTRL_PAT_EN];

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);

  localparam int A_EXIT = `ACS_TD_RST_CYC;
  localparam int A_CONV = `ACS_TCONV_CYC;

  sequence s_long_end;
    cs_rise && q.frame && (q.cnt >= FULL_CNT) && adr_ok;
  endsequence

  sequence s_rdy_hold;
    (!READY_STATUS_OUT)[*5];
  endsequence

  property p_rst_quiet;
    (q.st == ACS_RST) |-> !READY_STATUS_OUT && !SDO_OE;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("ready or data driven in reset");

  property p_exit;
    $rose(q.st == ACS_EXIT) |-> ##A_EXIT (q.st == ACS_ACQ) && (READY_STATUS_OUT || q.frame);
  endproperty
  a_exit: assert property (p_exit) else $error("reset exit delay wrong");

  property p_start;
    (q.st == ACS_ACQ) && conv_rise |=> (q.st == ACS_CNV) && !READY_STATUS_OUT;
  endproperty
  a_start: assert property (p_start) else $error("start edge did not begin conversion");

  property p_conv_len;
    $rose(q.st == ACS_CNV) |-> ##A_CONV (q.st == ACS_ACQ) && (q.result == acs_sat($past(CONV_RAW)));
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length or result wrong");

  property p_mirror;
    !q.frame && q.rdy_ok |-> (READY_STATUS_OUT == (q.st == ACS_ACQ));
  endproperty
  a_mirror: assert property (p_mirror) else $error("ready does not follow status");

  property p_load;
    cs_fall |=> (q.output_shift_register == $past(word)) && (q.cnt == 5'h00) && (q.input_shift_register == 22'h000000) && SDO_OE;
  endproperty
  a_load: assert property (p_load) else $error("frame start load wrong");

  property p_end;
    cs_rise |=> !SDO_OE ##0 s_rdy_hold;
  endproperty
  a_end: assert property (p_end) else $error("frame end float or ready delay wrong");

  property p_write;
    s_long_end and (cmd_opc == `ACS_OPC_WR) |=> q.regs[$past(adr_idx)] == $past(cmd_dat);
  endproperty
  a_write: assert property (p_write) else $error("register write lost");

  property p_clear;
    s_long_end and (cmd_opc == `ACS_OPC_CLR)
      |=> q.regs[$past(adr_idx)] == ($past(q.regs[adr_idx]) & ~$past(cmd_dat));
  endproperty
  a_clear: assert property (p_clear) else $error("masked clear wrong");

  property p_short;
    cs_rise && (q.cnt < FULL_CNT) |=> $stable(q.regs) && !q.rd_pend;
  endproperty
  a_short: assert property (p_short) else $error("short frame changed state");

  property p_set;
    s_long_end and (cmd_opc == `ACS_OPC_SET)
      |=> q.regs[$past(adr_idx)] == ($past(q.regs[adr_idx]) | $past(cmd_dat));
  endproperty
  a_set: assert property (p_set) else $error("masked set wrong");

  property p_read;
    s_long_end and (cmd_opc == `ACS_OPC_RD)
      |=> q.rd_pend && (q.rd_byte == $past(q.regs[adr_idx]));
  endproperty
  a_read: assert property (p_read) else $error("readback byte not captured");

  property p_shift_in;
    q.frame && !cs_fall && !cs_rise && sclk_rise |=> q.input_shift_register == {$past(q.input_shift_register[20:0]), $past(sdi_s)};
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("input bit not shifted in");

  property p_shift_out;
    q.frame && !cs_fall && !cs_rise && sclk_fall |=> q.output_shift_register == {$past(q.output_shift_register[20:0]), 1'b0};
  endproperty
  a_shift_out: assert property (p_shift_out) else $error("output bit not shifted out");

  sequence s_full_end;
    cs_rise && q.frame && (q.cnt >= FULL_CNT);
  endsequence

  property p_nop;
    s_full_end and !(cmd_opc inside {`ACS_OPC_CLR, `ACS_OPC_RD, `ACS_OPC_WR, `ACS_OPC_SET})
      |=> $stable(q.regs) && !q.rd_pend;
  endproperty
  a_nop: assert property (p_nop) else $error("nop or reserved command changed state");

endmodule // acs_ctrl

//--- acs_host.sv
// host-side model: conversion starter and mode-0 frame master
`timescale 1ns/1ps
module acs_host (
  // clock
  input wire logic mclk,
  // requests from the bench, held until busy has come
  input wire logic kick_req,
  input wire logic xfer_req,
  input wire logic [21:0] req_cmd,
  input wire logic [7:0] req_len,
  output logic busy,
  output logic [21:0] got,
  // device pins
  output logic start,
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);
  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic kick(input int n);
    start = 1'b1;
    wait_n(n);
    start = 1'b0;
  endtask

  // link clock of 48 ns; only the last 22 bits sent form the command
  task automatic xfer(input logic [21:0] cmd, input int n);
    got = '0;
    cs_n = 1'b0;
    for (int k = 0; k < n; k++) begin
      sdi = (n - k <= 22) ? cmd[n-1-k] : 1'b1;
      wait_n(6);
      if (k < 22) got = {got[20:0], sdo};
      sclk = 1'b1;
      wait_n(6);
      sclk = 1'b0;
    end
    wait_n(6);
    cs_n = 1'b1;
    // a released data line must not keep showing its last bit
    sdi = ~sdi;
  endtask

  // idle levels while reset is released
  initial begin
    start = 1'b0;
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    busy = 1'b0;
    got = '0;
    forever begin
      @(posedge mclk);
      if (kick_req || xfer_req) begin
        @(negedge mclk);
        busy = 1'b1;
        if (kick_req) kick(int'(req_len));
        else xfer(req_cmd, int'(req_len));
        busy = 1'b0;
      end
    end
  end
endmodule // acs_host

//--- tb_top.sv
// self-checking bench of the converter state and frame controller
`timescale 1ns/1ps
module tb_top;
  logic mclk, rst_n, start, cs_n, sclk, sdi, sdo, oe, ready, convert_state, act, par, pat;
  logic signed [23:0] raw;
  logic [21:0] w;
  logic h_kick, h_xfer, h_busy, sdo_line;
  logic [21:0] h_cmd, h_got;
  logic [7:0] h_len;
  int num_errors = 0;
  int n_compared = 0;
  int sh[4] = '{16, 12, 8, 0};
  // raw core value beside the saturated code it must give
  logic [43:0] rows [8] = '{{24'h000000, 20'h00000}, {24'h000001, 20'h00001},
    {24'hFFFFFF, 20'hFFFFF}, {24'h07FFFF, 20'h7FFFF}, {24'hF80000, 20'h80000},
    {24'h080000, 20'h7FFFF}, {24'hF7FFFF, 20'h80000}, {24'h123456, 20'h7FFFF}};

  acs_ctrl #(.RAW_W(24)) i_acs_ctrl (
    .MCLK(mclk), .RESET_N(rst_n), .CONVERSION_START_IN(start), .CS_N(cs_n),
    .SCLK(sclk), .SDI(sdi), .SDO(sdo), .SDO_OE(oe), .READY_STATUS_OUT(ready),
    .CONV_RAW(raw), .CONVERT_STATE(convert_state), .CONVERSION_ACTIVE_FLAG(act),
    .PARITY_ENABLE(par), .PATTERN_OVERRIDE_ENABLE(pat)
  );

  acs_host i_acs_host (
    .mclk(mclk), .kick_req(h_kick), .xfer_req(h_xfer), .req_cmd(h_cmd), .req_len(h_len),
    .busy(h_busy), .got(h_got), .start(start), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
    .sdo(sdo_line)
  );

  // a floated data line reads as the inverse of the last bit
  assign sdo_line = oe ? sdo : ~sdo;

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [21:0] seen, input logic [21:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic note(input string s);
    $display("test %s done", s);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // hand one request to the host model and wait until it is carried out
  task automatic host_go(input logic is_xfer, input logic [21:0] c, input int n);
    int i;
    logic ok;
    h_cmd = c;
    h_len = 8'(n);
    h_kick = !is_xfer;
    h_xfer = is_xfer;
    for (i = 0; i < 8 && h_busy !== 1'b1; i++) @(posedge mclk);
    ok = (h_busy === 1'b1);
    @(negedge mclk);
    h_kick = 1'b0;
    h_xfer = 1'b0;
    for (i = 0; i < 1000 && h_busy !== 1'b0; i++) @(posedge mclk);
    @(negedge mclk);
    if (!ok || h_busy !== 1'b0) begin
      num_errors++;
      complete_run();
    end
  endtask

  task automatic wait_rdy();
    int i;
    for (i = 0; i < 400 && ready !== 1'b1; i++) @(negedge mclk);
    if (ready !== 1'b1) begin
      num_errors++;
      complete_run();
    end
  endtask

  task automatic cmd(input logic [4:0] op, input logic [8:0] adr, input logic [7:0] dat,
                     input int n);
    host_go(1'b1, {op, adr, dat}, n);
    w = h_got;
    wait_rdy();
  endtask

  task automatic conv(input logic [23:0] r);
    raw = r;
    host_go(1'b0, 22'h000000, 4);
    wait_n(8);
    chk(22'({convert_state, act, ready}), 22'h4);
    wait_rdy();
  endtask

  initial begin
    rst_n = 1'b0;
    raw = '0;
    h_kick = 1'b0;
    h_xfer = 1'b0;
    h_cmd = 22'h000000;
    h_len = 8'h00;
    repeat (8) @(negedge mclk);
    chk(22'({ready, oe, convert_state, par, pat}), 22'h0);
    rst_n = 1'b1;
    repeat (200) @(negedge mclk);
    chk(22'(ready), 22'h0);
    wait_rdy();
    chk(22'({act, convert_state}), 22'h2);
    note("reset");
    foreach (rows[k]) begin
      conv(rows[k][43:20]);
      cmd(5'h00, 9'h000, 8'h00, 22);
      chk(w, {rows[k][19:0], 2'b00});
    end
    note("rows");
    // second start edge lands inside the conversion
    host_go(1'b0, 22'h000000, 4);
    wait_n(20);
    host_go(1'b0, 22'h000000, 4);
    wait_rdy();
    wait_n(10);
    chk(22'({convert_state, ready}), 22'h1);
    note("start during conversion");
    fork
      cmd(5'h12, 9'h000, 8'h01, 22);
      begin
        wait_n(30);
        chk(22'({oe, ready}), 22'h2);
      end
    join
    chk(22'({oe, par}), 22'h1);
    note("frame");
    conv(24'h012345);
    for (int s = 0; s < 4; s++) begin
      cmd(5'h12, 9'h000, 8'(2 * s + 1), 22);
      cmd(5'h00, 9'h000, 8'h00, 22);
      chk(w, {20'h12345, ^20'h12345, ^(20'h12345 >> sh[s])});
    end
    note("parity");
    cmd(5'h13, 9'h000, 8'h08, 22);
    cmd(5'h10, 9'h000, 8'h01, 22);
    chk(22'({pat, par}), 22'h2);
    cmd(5'h12, 9'h001, 8'hDE, 22);
    cmd(5'h12, 9'h002, 8'hBC, 22);
    cmd(5'h12, 9'h003, 8'h0A, 22);
    cmd(5'h11, 9'h000, 8'h00, 22);
    cmd(5'h00, 9'h000, 8'h00, 22);
    chk(w, {8'h0E, 14'h0});
    cmd(5'h15, 9'h000, 8'h00, 22);
    chk(w, {20'hABCDE, 2'b00});
    cmd(5'h1F, 9'h1FF, 8'hFF, 22);
    cmd(5'h12, 9'h000, 8'h00, 21);
    chk(22'(w[20:0]), 22'({20'hABCDE, 2'b00} >> 1));
    cmd(5'h11, 9'h000, 8'h00, 22);
    cmd(5'h00, 9'h000, 8'h00, 22);
    chk(w, {8'h0E, 14'h0});
    cmd(5'h12, 9'h000, 8'h00, 30);
    chk(22'({pat, par}), 22'h0);
    note("commands");
    cmd(5'h13, 9'h000, 8'h01, 22);
    rst_n = 1'b0;
    repeat (8) @(negedge mclk);
    chk(22'({ready, oe, par}), 22'h0);
    rst_n = 1'b1;
    wait_rdy();
    note("second reset");
    complete_run();
  end
endmodule // tb_top
